// >>> psr_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps

module psr_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int unsigned PW = $clog2(DEPTH) + 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr_ptr;
    logic [PW-1:0]               rd_ptr;
  } psr_fifo_st_t;

  psr_fifo_st_t st_q;
  psr_fifo_st_t st_d;
  logic         full;
  logic         empty;

  // ************************************************************
  // status and pointers
  // ************************************************************
  assign empty     = (st_q.wr_ptr == st_q.rd_ptr);
  assign full      = (st_q.wr_ptr[PW-2:0] == st_q.rd_ptr[PW-2:0]) && !empty;
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = st_q.mem[st_q.rd_ptr[PW-2:0]];

  always_comb
  begin
    st_d = st_q;
    if (in_valid && !full)
    begin
      st_d.mem[st_q.wr_ptr[PW-2:0]] = in_data;
      st_d.wr_ptr = st_q.wr_ptr + PW'(1);
    end
    if (out_ready && !empty)
    begin
      st_d.rd_ptr = st_q.rd_ptr + PW'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q.wr_ptr <= '0;
      st_q.rd_ptr <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

endmodule // psr_fifo

// >>> psr_pkg.sv
// constants and types shared by the shift register and its command fifo
package psr_pkg;

  // ************************************************************
  // register geometry
  // ************************************************************
  localparam int unsigned STAGES     = 8;
  localparam int unsigned TAP_LO     = 5;
  localparam int unsigned TAP_W      = 3;
  localparam int unsigned FILL_W     = 4;
  localparam logic [3:0]  FILL_FULL  = 4'h8;
  localparam logic [3:0]  FILL_ONE   = 4'h1;
  localparam logic [3:0]  FILL_EMPTY = 4'h0;

  // ************************************************************
  // command word queued on each rising shift_clock edge that finds the fifo not full
  // ************************************************************
  localparam int unsigned CMD_W       = STAGES + 2;
  localparam int unsigned CMD_PAR_LO  = 0;
  localparam int unsigned CMD_SER_BIT = STAGES;
  localparam int unsigned CMD_LD_BIT  = STAGES + 1;
  localparam int unsigned FIFO_DEPTH  = 4;

  // ************************************************************
  // core states
  // ************************************************************
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_APPLY = 2'h1
  } psr_state_t;

endpackage : psr_pkg

// >>> psr_shift_reg.sv
// eight-stage shift register with parallel load and three buffered taps
`timescale 1ns/100ps

// Summary of operation
// RL1 - eight stages, changed only on clock edges
// RL2 - act on rising shift clock edge only
// RL3 - select low: shift toward last, serial in
// RL4 - select high: load all eight parallel inputs
// RL5 - only stages five to seven are outputs
// RL6 - first serial bit reaches tap five after six
// RL7 - falling edge leaves taps unchanged
// RL8 - no reset of stage contents
module psr_shift_reg #(
  parameter int unsigned DEPTH = psr_pkg::FIFO_DEPTH
) (
  input  wire logic                                 sys_clk,
  input  wire logic                                 rstn,
  input  wire logic                                 shift_clock,
  input  wire logic                                 load_select,
  input  wire logic                                 serial_in,
  input  wire logic [psr_pkg::STAGES-1:0]           parallel_in,
  output logic                                      edge_ready,
  output logic                                      overrun,
  output logic      [psr_pkg::TAP_W-1:0]            tap_out,
  output logic                                      tap_valid,
  input  wire logic                                 tap_ready,
  output logic                                      stages_full
);

  typedef struct packed {
    logic                           clk_prev;
    psr_pkg::psr_state_t            state;
    logic [psr_pkg::CMD_W-1:0]      cmd;
    logic [psr_pkg::STAGES-1:0]     stages;
    logic [psr_pkg::FILL_W-1:0]     fill;
    logic                           overrun;
    logic                           tap_valid;
  } psr_core_st_t;

  psr_core_st_t                   st_q;
  psr_core_st_t                   st_d;
  logic [1:0]                     rst_sync_q;
  logic                           rst_n;
  logic                           rise;
  logic                           push_ready;
  logic                           pop_valid;
  logic                           pop;
  logic [psr_pkg::CMD_W-1:0]      push_data;
  logic [psr_pkg::CMD_W-1:0]      pop_data;

  // ************************************************************
  // reset release through two flip-flops
  // ************************************************************
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_sync_q <= 2'h0;
    end
    else
    begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // ************************************************************
  // edge detection and command queue
  // ************************************************************
  // only a low-to-high step of shift_clock queues a command
  assign rise      = shift_clock && !st_q.clk_prev; // [RL2] [RL7]
  assign push_data = {load_select, serial_in, parallel_in};
  assign pop       = (st_q.state == psr_pkg::ST_IDLE) && pop_valid && tap_ready;

  psr_fifo #(
    .WIDTH (psr_pkg::CMD_W),
    .DEPTH (DEPTH)
  ) u_cmd_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (rise),
    .in_ready  (push_ready),
    .in_data   (push_data),
    .out_valid (pop_valid),
    .out_ready (pop),
    .out_data  (pop_data)
  );

  // ************************************************************
  // core next state
  // ************************************************************
  always_comb
  begin
    st_d           = st_q;
    st_d.clk_prev  = shift_clock;
    st_d.tap_valid = 1'b0;
    // an edge that finds the queue full is lost and remembered
    if (rise && !push_ready)
    begin
      st_d.overrun = 1'b1;
    end
    case (st_q.state)
      psr_pkg::ST_IDLE:
      begin
        if (pop)
        begin
          st_d.cmd   = pop_data;
          st_d.state = psr_pkg::ST_APPLY;
        end
      end
      psr_pkg::ST_APPLY:
      begin
        if (st_q.cmd[psr_pkg::CMD_LD_BIT])
        begin
          // all eight stages taken at once
          st_d.stages = st_q.cmd[psr_pkg::CMD_PAR_LO +: psr_pkg::STAGES]; // [RL4]
          st_d.fill   = psr_pkg::FILL_FULL;
        end
        else
        begin
          // stage i takes stage i-1, stage 0 takes the serial bit
          st_d.stages = {st_q.stages[psr_pkg::STAGES-2:0],
                         st_q.cmd[psr_pkg::CMD_SER_BIT]}; // [RL3] [RL6]
          if (st_q.fill != psr_pkg::FILL_FULL)
          begin
            st_d.fill = st_q.fill + psr_pkg::FILL_ONE;
          end
        end
        st_d.tap_valid = 1'b1;
        st_d.state     = psr_pkg::ST_IDLE;
      end
      default:
      begin
        st_d.state = psr_pkg::ST_IDLE;
      end
    endcase
  end

  // ************************************************************
  // state register
  // ************************************************************
  // stage contents carry no reset; they hold through reset [RL8]
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q.clk_prev  <= 1'b1;
      st_q.state     <= psr_pkg::ST_IDLE;
      st_q.cmd       <= '0;
      st_q.fill      <= psr_pkg::FILL_EMPTY;
      st_q.overrun   <= 1'b0;
      st_q.tap_valid <= 1'b0;
    end
    else
    begin
      st_q <= st_d; // [RL1]
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign tap_out     = st_q.stages[psr_pkg::TAP_LO +: psr_pkg::TAP_W]; // [RL5]
  assign tap_valid   = st_q.tap_valid;
  assign edge_ready  = push_ready;
  assign overrun     = st_q.overrun;
  assign stages_full = (st_q.fill == psr_pkg::FILL_FULL);

endmodule // psr_shift_reg

// >>> psr_shift_reg_properties.sv
// port checker for the shift register
`timescale 1ns/100ps
module psr_chk #(
  parameter int unsigned DEPTH = 4
) (
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic       shift_clock,
  input wire logic       edge_ready,
  input wire logic       overrun,
  input wire logic [2:0] tap_out,
  input wire logic       tap_valid,
  input wire logic       tap_ready,
  input wire logic       stages_full
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_tap_hold: assert property ($changed(tap_out) |-> tap_valid)
    else $error("taps moved");
  a_valid_pulse: assert property (tap_valid |=> !tap_valid)
    else $error("valid too long");
  a_apply_ready: assert property (tap_valid |-> $past(tap_ready, 2))
    else $error("applied while stalled");
  a_refuse_flag: assert property ($rose(shift_clock) && !edge_ready |=> overrun)
    else $error("overrun missed");
  a_overrun_hold: assert property (overrun |=> overrun)
    else $error("overrun lost");
  a_full_hold: assert property (stages_full |=> stages_full)
    else $error("full lost");
  a_rst_status: assert property ($rose(rstn) |-> edge_ready && !overrun && !stages_full)
    else $error("bad reset status");
  a_answer_bound: assert property (($rose(shift_clock) && edge_ready && tap_ready
    ##1 tap_ready [*3]) |-> ##[0:4] tap_valid)
    else $error("no update");
endmodule // psr_chk

bind psr_shift_reg psr_chk #(.DEPTH(DEPTH)) i_chk (.sys_clk(sys_clk), .rstn(rstn),
  .shift_clock(shift_clock), .edge_ready(edge_ready), .overrun(overrun),
  .tap_out(tap_out), .tap_valid(tap_valid), .tap_ready(tap_ready),
  .stages_full(stages_full));

// >>> psr_shift_reg_tb.sv
// self-checking bench for the shift register
`timescale 1ns/100ps
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin err_count++; \
  $display("mismatch %s exp %0h got %0h", nm, e, a); end end
module psr_shift_reg_tb;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        shift_clock = 1'b1;
  logic        load_select = 1'b0;
  logic        serial_in = 1'b0;
  logic [7:0]  parallel_in = 8'h00;
  logic        stall = 1'b0;
  logic        edge_ready, overrun, tap_valid, tap_ready, stages_full;
  logic [2:0]  tap_out;
  int          err_count = 0;
  int          checks = 0;
  int          n;
  // load, serial bit, parallel word, expected taps
  logic [12:0] rows [5] = '{{1'b1, 1'b0, 8'ha5, 3'h5}, {1'b0, 1'b1, 8'h00, 3'h2},
    {1'b0, 1'b0, 8'h00, 3'h4}, {1'b1, 1'b0, 8'h3c, 3'h1}, {1'b1, 1'b0, 8'he0, 3'h7}};

  psr_shift_reg i_dut (.sys_clk(sys_clk), .rstn(rstn), .shift_clock(shift_clock),
    .load_select(load_select), .serial_in(serial_in), .parallel_in(parallel_in),
    .edge_ready(edge_ready), .overrun(overrun), .tap_out(tap_out),
    .tap_valid(tap_valid), .tap_ready(tap_ready), .stages_full(stages_full));
  psr_sink i_sink (.sys_clk(sys_clk), .stall(stall), .tap_ready(tap_ready));

  initial forever #5 sys_clk = ~sys_clk;

  task step;
    @(posedge sys_clk);
    #1;
  endtask

  task edge_cmd(input logic ld, input logic s, input logic [7:0] p);
    step;
    shift_clock = 1'b1;
    load_select = ld;
    serial_in = s;
    parallel_in = p;
    step;
    shift_clock = 1'b0;
  endtask

  task wait_valid;
    for (int k = 0; k < 20 && tap_valid !== 1'b1; k++) step;
    `CHK("tap_valid", 1'b1, tap_valid)
  endtask

  task end_of_test;
    if (err_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial
  begin
    #50000;
    err_count++;
    end_of_test;
  end

  initial
  begin
    repeat (3) @(posedge sys_clk);
    #1 rstn = 1'b1;
    repeat (4) step;
    load_select = 1'b1;
    parallel_in = 8'hff;
    shift_clock = 1'b0;
    repeat (6)
    begin
      step;
      `CHK("tap_valid", 1'b0, tap_valid)
    end
    `CHK("stages_full", 1'b0, stages_full)
    foreach (rows[i])
    begin
      edge_cmd(rows[i][12], rows[i][11], rows[i][10:3]);
      wait_valid;
      `CHK("tap_out", rows[i][2:0], tap_out)
    end
    `CHK("stages_full", 1'b1, stages_full)
    edge_cmd(1'b1, 1'b0, 8'h00);
    wait_valid;
    for (n = 1; n <= 8; n++)
    begin
      edge_cmd(1'b0, n == 1, 8'h00);
      wait_valid;
      `CHK("tap_out", (n > 5) ? 3'h1 << (n - 6) : 3'h0, tap_out)
    end
    stall = 1'b1;
    for (n = 1; n < 8 && edge_ready === 1'b1; n++) edge_cmd(1'b1, 1'b0, {3'(n), 5'h00});
    `CHK("accepted", psr_pkg::FIFO_DEPTH, n - 1)
    edge_cmd(1'b1, 1'b0, 8'ha0);
    step;
    `CHK("overrun", 1'b1, overrun)
    stall = 1'b0;
    repeat (20) step;
    `CHK("tap_out", 3'h4, tap_out)
    `CHK("edge_ready", 1'b1, edge_ready)
    // reset in mid-run: status clears, stages keep their contents
    rstn = 1'b0;
    shift_clock = 1'b1;
    load_select = 1'b1;
    parallel_in = 8'h00;
    step;
    `CHK("overrun", 1'b0, overrun)
    `CHK("stages_full", 1'b0, stages_full)
    `CHK("tap_valid", 1'b0, tap_valid)
    `CHK("tap_out", 3'h4, tap_out)
    repeat (2) step;
    rstn = 1'b1;
    repeat (4) step;
    // shift_clock high at release is no rising step; now only a falling one
    shift_clock = 1'b0;
    repeat (4)
    begin
      step;
      `CHK("tap_valid", 1'b0, tap_valid)
    end
    `CHK("tap_out", 3'h4, tap_out)
    edge_cmd(1'b1, 1'b0, 8'h60);
    wait_valid;
    `CHK("tap_out", 3'h3, tap_out)
    `CHK("stages_full", 1'b1, stages_full)
    end_of_test;
  end
endmodule // psr_shift_reg_tb

// >>> psr_sink.sv
// far-side consumer of the taps, able to stall
`timescale 1ns/100ps
module psr_sink (
  input  wire logic sys_clk,
  input  wire logic stall,
  output logic      tap_ready
);
  initial tap_ready = 1'b1;
  always @(posedge sys_clk) tap_ready <= !stall;
endmodule // psr_sink
